// ===== clock_gating_register_interface.sv
// Clock gating controller: register file, write guard, event interrupt and gates.
//
// Behaviour
// - A one written to a programmable clock bit of the enable port turns that output on, zeros change nothing.
// - A one written to a programmable clock bit of the disable port turns that output off, zeros change nothing.
// - The system clock state register shows in bits 8 to 10 which programmable clock outputs are on.
// - A one written to peripheral bits 2 to 31 of the peripheral enable port turns that clock on, zeros do nothing.
// - A one written to a peripheral bit of the peripheral disable port turns that clock off, zeros do nothing.
// - The peripheral clock state register shows in bits 2 to 31 which peripheral clocks are on.
// - Writes to the clock enable and disable ports are ignored while the write guard is on.
// - Control bits of peripherals that are not implemented have no effect at all.
// - After reset the system clock state register reads 0x0000_0001.
// - After reset the peripheral clock state register reads 0x0000_0000.
// - After reset the controller status reads 0x0001_0008 and the interrupt mask reads zero.
// - A blocked write sets the violation flag with its target recorded, and reading the guard status clears it.
// - Each enabled peripheral clock is the master clock gated, never divided.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module clock_gating_register_interface #(
  parameter logic [31:0] PERIPH_IMPL = 32'hffff_fffc
) (
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst,
  input  wire clock_gate_pkg::bus_req_t   i_bus,
  output logic [31:0]                     o_rdata,
  output logic [2:0]                      o_prog_clk_on,
  output logic [31:0]                     o_periph_clk,
  output logic                            o_irq
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (PERIPH_IMPL[1:0] != 2'h0)
  begin : g_bad_impl
    $error("Peripheral identifiers 0 and 1 cannot be implemented.");
  end

  // ****************************************
  // Decode
  // ****************************************
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        guard_on;
  logic        protected_hit;
  logic        wr_ok;

  assign wr    = i_bus.wr;
  assign rd    = i_bus.rd;
  assign addr  = i_bus.addr;
  assign wdata = i_bus.wdata;

  always_comb
  begin
    unique case (addr)
      clock_gate_pkg::OFS_SYS_CLK_ENABLE,
      clock_gate_pkg::OFS_SYS_CLK_DISABLE,
      clock_gate_pkg::OFS_PERIPH_CLK_ENABLE,
      clock_gate_pkg::OFS_PERIPH_CLK_DISABLE,
      clock_gate_pkg::OFS_USB_PLL_CONFIG,
      clock_gate_pkg::OFS_MAIN_OSC_CONFIG,
      clock_gate_pkg::OFS_PLL_A_CONFIG,
      clock_gate_pkg::OFS_PROG_CLK_0_CONFIG,
      clock_gate_pkg::OFS_PROG_CLK_1_CONFIG,
      clock_gate_pkg::OFS_PROG_CLK_2_CONFIG,
      clock_gate_pkg::OFS_FAST_WAKE_MODE,
      clock_gate_pkg::OFS_FAST_WAKE_POLARITY: protected_hit = 1'b1;
      default:                                protected_hit = 1'b0;
    endcase
  end

  // A write to a protected register passes only while the guard is off.
  assign wr_ok = wr & ~(protected_hit & guard_on);

  // ****************************************
  // Programmable clock outputs
  // ****************************************
  logic [2:0] prog_on_r;
  logic [2:0] prog_set;
  logic [2:0] prog_clr;

  assign prog_set = (wr_ok && addr == clock_gate_pkg::OFS_SYS_CLK_ENABLE) ?
    wdata[clock_gate_pkg::PROG_CLK_LSB +: clock_gate_pkg::PROG_CLK_COUNT] :
    3'h0;
  assign prog_clr = (wr_ok && addr == clock_gate_pkg::OFS_SYS_CLK_DISABLE) ?
    wdata[clock_gate_pkg::PROG_CLK_LSB +: clock_gate_pkg::PROG_CLK_COUNT] :
    3'h0;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prog_on_r <= 3'h0;
    end
    else
    begin
      prog_on_r <= (prog_on_r | prog_set) & ~prog_clr;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_prog_clk_on <= 3'h0;
    end
    else
    begin
      o_prog_clk_on <= prog_on_r;
    end
  end

  // ****************************************
  // Peripheral clock enables
  // ****************************************
  logic [31:0] periph_on_r;
  logic [31:0] periph_set;
  logic [31:0] periph_clr;

  assign periph_set = (wr_ok && addr == clock_gate_pkg::OFS_PERIPH_CLK_ENABLE) ?
    (wdata & PERIPH_IMPL) : 32'h0000_0000;
  assign periph_clr =
    (wr_ok && addr == clock_gate_pkg::OFS_PERIPH_CLK_DISABLE) ?
    (wdata & PERIPH_IMPL) : 32'h0000_0000;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      periph_on_r <= clock_gate_pkg::RST_PERIPH_CLK_STATE;
    end
    else
    begin
      periph_on_r <= (periph_on_r | periph_set) & ~periph_clr;
    end
  end

  // ****************************************
  // Glitch-free gates on the master clock
  // ****************************************
  // The enable is retimed on the falling edge, so it only moves while the
  // master clock is low and the AND cannot clip a high phase.
  for (genvar g = 0; g < 32; g++)
  begin : g_gate
    if (PERIPH_IMPL[g])
    begin : g_impl
      logic gate_en_lo_r;
      always_ff @(negedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          gate_en_lo_r <= 1'b0;
        end
        else
        begin
          gate_en_lo_r <= periph_on_r[g];
        end
      end
      assign o_periph_clk[g] = i_mclk & gate_en_lo_r;
    end
    else
    begin : g_none
      assign o_periph_clk[g] = 1'b0;
    end
  end

  // ****************************************
  // Plain configuration registers
  // ****************************************
  logic [31:0] usb_pll_r;
  logic [31:0] main_osc_r;
  logic [31:0] pll_a_r;
  logic [31:0] master_clk_r;
  logic [31:0] prog_cfg_r [3];
  logic [31:0] wake_mode_r;
  logic [31:0] wake_pol_r;
  logic [31:0] guard_mode_r;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      usb_pll_r    <= clock_gate_pkg::RST_USB_PLL_CONFIG;
      main_osc_r   <= clock_gate_pkg::RST_MAIN_OSC_CONFIG;
      pll_a_r      <= clock_gate_pkg::RST_PLL_A_CONFIG;
      master_clk_r <= clock_gate_pkg::RST_MASTER_CLK_CONFIG;
      prog_cfg_r[0] <= clock_gate_pkg::RST_ZERO;
      prog_cfg_r[1] <= clock_gate_pkg::RST_ZERO;
      prog_cfg_r[2] <= clock_gate_pkg::RST_ZERO;
      wake_mode_r  <= clock_gate_pkg::RST_ZERO;
      wake_pol_r   <= clock_gate_pkg::RST_ZERO;
      guard_mode_r <= clock_gate_pkg::RST_ZERO;
    end
    else if (wr_ok)
    begin
      unique case (addr)
        clock_gate_pkg::OFS_USB_PLL_CONFIG:     usb_pll_r    <= wdata;
        clock_gate_pkg::OFS_MAIN_OSC_CONFIG:    main_osc_r   <= wdata;
        clock_gate_pkg::OFS_PLL_A_CONFIG:       pll_a_r      <= wdata;
        clock_gate_pkg::OFS_MASTER_CLK_CONFIG:  master_clk_r <= wdata;
        clock_gate_pkg::OFS_PROG_CLK_0_CONFIG:  prog_cfg_r[0] <= wdata;
        clock_gate_pkg::OFS_PROG_CLK_1_CONFIG:  prog_cfg_r[1] <= wdata;
        clock_gate_pkg::OFS_PROG_CLK_2_CONFIG:  prog_cfg_r[2] <= wdata;
        clock_gate_pkg::OFS_FAST_WAKE_MODE:     wake_mode_r  <= wdata;
        clock_gate_pkg::OFS_FAST_WAKE_POLARITY: wake_pol_r   <= wdata;
        clock_gate_pkg::OFS_WRITE_GUARD_MODE:   guard_mode_r <= wdata;
        default:                                ;
      endcase
    end
  end

  assign guard_on = guard_mode_r[clock_gate_pkg::WRITE_GUARD_ON_BIT];

  // ****************************************
  // Interrupt mask
  // ****************************************
  logic [31:0] irq_mask_r;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_mask_r <= clock_gate_pkg::RST_ZERO;
    end
    else if (wr && addr == clock_gate_pkg::OFS_IRQ_ENABLE)
    begin
      irq_mask_r <= irq_mask_r | wdata;
    end
    else if (wr && addr == clock_gate_pkg::OFS_IRQ_DISABLE)
    begin
      irq_mask_r <= irq_mask_r & ~wdata;
    end
  end

  // ****************************************
  // Write guard violation
  // ****************************************
  logic        violation_r;
  logic [15:0] violation_src_r;
  logic        violation_hit;
  logic        guard_status_rd;

  assign violation_hit   = wr & protected_hit & guard_on;
  assign guard_status_rd = rd &&
    addr == clock_gate_pkg::OFS_WRITE_GUARD_STATUS;

  // A new violation in the cycle of the clearing read stays set.
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      violation_r     <= 1'b0;
      violation_src_r <= 16'h0000;
    end
    else if (violation_hit)
    begin
      violation_r     <= 1'b1;
      violation_src_r <= {8'h00, addr};
    end
    else if (guard_status_rd)
    begin
      violation_r <= 1'b0;
    end
  end

  // ****************************************
  // Event status and interrupt
  // ****************************************
  logic [31:0] event_status_r;
  logic [31:0] event_enable_r;
  logic [31:0] event_set;
  logic [31:0] event_clr;

  always_comb
  begin
    event_set = 32'h0000_0000;
    event_set[clock_gate_pkg::EVENT_VIOLATION_BIT] = violation_hit;
    event_set[clock_gate_pkg::PROG_CLK_LSB +: clock_gate_pkg::PROG_CLK_COUNT] =
      prog_set & ~prog_on_r;
  end

  assign event_clr = (wr && addr == clock_gate_pkg::OFS_EVENT_CLEAR) ?
    wdata : 32'h0000_0000;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      event_status_r <= clock_gate_pkg::RST_ZERO;
    end
    else
    begin
      event_status_r <= (event_status_r & ~event_clr) | event_set;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      event_enable_r <= clock_gate_pkg::RST_ZERO;
    end
    else if (wr && addr == clock_gate_pkg::OFS_EVENT_ENABLE)
    begin
      event_enable_r <= wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(event_status_r & event_enable_r);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr)
      clock_gate_pkg::OFS_SYS_CLK_STATE:
      begin
        rd_mux = clock_gate_pkg::RST_SYS_CLK_STATE;
        rd_mux[clock_gate_pkg::PROG_CLK_LSB +: clock_gate_pkg::PROG_CLK_COUNT] =
          prog_on_r;
      end
      clock_gate_pkg::OFS_PERIPH_CLK_STATE:  rd_mux = periph_on_r;
      clock_gate_pkg::OFS_USB_PLL_CONFIG:    rd_mux = usb_pll_r;
      clock_gate_pkg::OFS_MAIN_OSC_CONFIG:   rd_mux = main_osc_r;
      clock_gate_pkg::OFS_MAIN_CLK_FREQ:
        rd_mux = clock_gate_pkg::RST_MAIN_CLK_FREQ;
      clock_gate_pkg::OFS_PLL_A_CONFIG:      rd_mux = pll_a_r;
      clock_gate_pkg::OFS_MASTER_CLK_CONFIG: rd_mux = master_clk_r;
      clock_gate_pkg::OFS_PROG_CLK_0_CONFIG: rd_mux = prog_cfg_r[0];
      clock_gate_pkg::OFS_PROG_CLK_1_CONFIG: rd_mux = prog_cfg_r[1];
      clock_gate_pkg::OFS_PROG_CLK_2_CONFIG: rd_mux = prog_cfg_r[2];
      clock_gate_pkg::OFS_CONTROLLER_STATUS:
        rd_mux = clock_gate_pkg::RST_CONTROLLER_STATUS;
      clock_gate_pkg::OFS_IRQ_MASK:          rd_mux = irq_mask_r;
      clock_gate_pkg::OFS_FAST_WAKE_MODE:    rd_mux = wake_mode_r;
      clock_gate_pkg::OFS_FAST_WAKE_POLARITY: rd_mux = wake_pol_r;
      clock_gate_pkg::OFS_EVENT_STATUS:      rd_mux = event_status_r;
      clock_gate_pkg::OFS_EVENT_ENABLE:      rd_mux = event_enable_r;
      clock_gate_pkg::OFS_WRITE_GUARD_MODE:  rd_mux = guard_mode_r;
      clock_gate_pkg::OFS_WRITE_GUARD_STATUS:
      begin
        rd_mux[clock_gate_pkg::VIOLATION_BIT] = violation_r;
        rd_mux[clock_gate_pkg::VIOLATION_SRC_LSB +: 16] = violation_src_r;
      end
      default:                               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= 32'h0000_0000;
    end
    else if (rd)
    begin
      o_rdata <= rd_mux;
    end
    else
    begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ===== clock_gate_pkg.sv
// Register map, reset values, field layouts and bus types of the clock gating block.
`default_nettype none
package clock_gate_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_SYS_CLK_ENABLE    = 8'h00;
  localparam logic [7:0] OFS_SYS_CLK_DISABLE   = 8'h04;
  localparam logic [7:0] OFS_SYS_CLK_STATE     = 8'h08;
  localparam logic [7:0] OFS_PERIPH_CLK_ENABLE = 8'h10;
  localparam logic [7:0] OFS_PERIPH_CLK_DISABLE = 8'h14;
  localparam logic [7:0] OFS_PERIPH_CLK_STATE  = 8'h18;
  localparam logic [7:0] OFS_USB_PLL_CONFIG    = 8'h1c;
  localparam logic [7:0] OFS_MAIN_OSC_CONFIG   = 8'h20;
  localparam logic [7:0] OFS_MAIN_CLK_FREQ     = 8'h24;
  localparam logic [7:0] OFS_PLL_A_CONFIG      = 8'h28;
  localparam logic [7:0] OFS_MASTER_CLK_CONFIG = 8'h30;
  localparam logic [7:0] OFS_PROG_CLK_0_CONFIG = 8'h40;
  localparam logic [7:0] OFS_PROG_CLK_1_CONFIG = 8'h44;
  localparam logic [7:0] OFS_PROG_CLK_2_CONFIG = 8'h48;
  localparam logic [7:0] OFS_IRQ_ENABLE        = 8'h60;
  localparam logic [7:0] OFS_IRQ_DISABLE       = 8'h64;
  localparam logic [7:0] OFS_CONTROLLER_STATUS = 8'h68;
  localparam logic [7:0] OFS_IRQ_MASK          = 8'h6c;
  localparam logic [7:0] OFS_FAST_WAKE_MODE    = 8'h70;
  localparam logic [7:0] OFS_FAST_WAKE_POLARITY = 8'h74;
  localparam logic [7:0] OFS_FAULT_OUTPUT_CLEAR = 8'h78;
  localparam logic [7:0] OFS_EVENT_STATUS      = 8'h80;
  localparam logic [7:0] OFS_EVENT_CLEAR       = 8'h84;
  localparam logic [7:0] OFS_EVENT_ENABLE      = 8'h88;
  localparam logic [7:0] OFS_WRITE_GUARD_MODE  = 8'he4;
  localparam logic [7:0] OFS_WRITE_GUARD_STATUS = 8'he8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_SYS_CLK_STATE     = 32'h0000_0001;
  localparam logic [31:0] RST_PERIPH_CLK_STATE  = 32'h0000_0000;
  localparam logic [31:0] RST_USB_PLL_CONFIG    = 32'h1020_0800;
  localparam logic [31:0] RST_MAIN_OSC_CONFIG   = 32'h0000_0001;
  localparam logic [31:0] RST_MAIN_CLK_FREQ     = 32'h0000_0000;
  localparam logic [31:0] RST_PLL_A_CONFIG      = 32'h0000_3f00;
  localparam logic [31:0] RST_MASTER_CLK_CONFIG = 32'h0000_0001;
  localparam logic [31:0] RST_ZERO              = 32'h0000_0000;
  localparam logic [31:0] RST_CONTROLLER_STATUS = 32'h0001_0008;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PROG_CLK_LSB       = 8;
  localparam int PROG_CLK_COUNT     = 3;
  localparam int PERIPH_LSB         = 2;
  localparam int WRITE_GUARD_ON_BIT = 0;
  localparam int VIOLATION_BIT      = 0;
  localparam int VIOLATION_SRC_LSB  = 8;
  localparam int EVENT_VIOLATION_BIT = 0;

  // ****************************************
  // Register bus request
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage
`default_nettype wire

// ===== clock_gating_register_interface_assertions.sv
// Port checks of the clock gating controller, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module clock_gating_register_interface_checker #(
  parameter logic [31:0] PERIPH_IMPL = 32'hffff_fffc
) (
  input wire logic                     i_mclk,
  input wire logic                     i_rst,
  input wire clock_gate_pkg::bus_req_t i_bus,
  input wire logic [31:0]              o_rdata,
  input wire logic [2:0]               o_prog_clk_on,
  input wire logic [31:0]              o_periph_clk,
  input wire logic                     o_irq
);
  // *****
  // Shadow of the guard bit, of the peripheral clock state and of the event enable.
  // *****
  logic        guard_r;
  logic [31:0] ps_r;
  logic [31:0] en_r;
  logic        wr_ok;
  assign wr_ok = i_bus.wr && !guard_r;
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      guard_r <= 1'b0;
    else if (i_bus.wr && i_bus.addr == 8'he4)
      guard_r <= i_bus.wdata[0];
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      ps_r <= 32'h0000_0000;
    else if (wr_ok && i_bus.addr == 8'h10)
      ps_r <= ps_r | (i_bus.wdata & PERIPH_IMPL);
    else if (wr_ok && i_bus.addr == 8'h14)
      ps_r <= ps_r & ~(i_bus.wdata & PERIPH_IMPL);
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      en_r <= 32'h0000_0000;
    else if (i_bus.wr && i_bus.addr == 8'h88)
      en_r <= i_bus.wdata;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  AST_RDATA_IDLE: assert property (!i_bus.rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  AST_PROG_ON: assert property (wr_ok && i_bus.addr == 8'h00 |-> ##2
    (o_prog_clk_on & $past(i_bus.wdata[10:8], 2)) ==
    $past(i_bus.wdata[10:8], 2)) else $error("output not turned on");
  AST_PROG_OFF: assert property (wr_ok && i_bus.addr == 8'h04 |-> ##2
    (o_prog_clk_on & $past(i_bus.wdata[10:8], 2)) == 3'h0)
    else $error("output not turned off");
  AST_PROG_HOLD: assert property ($changed(o_prog_clk_on) |->
    $past(wr_ok, 2) && $past(i_bus.addr, 2) inside {8'h00, 8'h04})
    else $error("output changed without an accepted write");
  AST_SYS_STATE: assert property (i_bus.rd && i_bus.addr == 8'h08 |=>
    o_rdata == {21'h0, o_prog_clk_on, 8'h01})
    else $error("system clock state read wrong");
  AST_PERIPH_STATE: assert property (i_bus.rd && i_bus.addr == 8'h18
    |=> o_rdata == $past(ps_r)) else $error("peripheral state read wrong");
  AST_GATE_FOLLOWS: assert property (@(negedge i_mclk)
    o_periph_clk == $past(ps_r)) else $error("gated clocks wrong");
  AST_VIOL_RECORD: assert property ((i_bus.wr && guard_r &&
    i_bus.addr == 8'h10) ##1 (i_bus.rd && i_bus.addr == 8'he8) |=>
    o_rdata[0] && o_rdata[23:8] == 16'h0010)
    else $error("violation not recorded");
  AST_VIOL_CLEAR: assert property ((i_bus.rd && i_bus.addr == 8'he8)
    ##1 (i_bus.rd && i_bus.addr == 8'he8) |=> !o_rdata[0])
    else $error("violation flag not cleared by read");
  AST_IRQ_MASKED: assert property (en_r == 32'h0000_0000 |=> !o_irq)
    else $error("interrupt raised with every event masked");
endmodule
bind clock_gating_register_interface clock_gating_register_interface_checker #(
  .PERIPH_IMPL(PERIPH_IMPL)
) u_checker (
  .i_mclk        (i_mclk),
  .i_rst         (i_rst),
  .i_bus         (i_bus),
  .o_rdata       (o_rdata),
  .o_prog_clk_on (o_prog_clk_on),
  .o_periph_clk  (o_periph_clk),
  .o_irq         (o_irq)
);
`default_nettype wire

// ===== clock_gating_register_interface_tb_top.sv
// Random and directed self-checking bench of the clock gating controller.
`timescale 1ns/1ps
`default_nettype none
module clock_gating_register_interface_tb_top;
  localparam logic [31:0] IMPL = 32'h0fff_fffc;
  logic                     i_mclk = 1'b0;
  logic                     i_rst = 1'b1;
  clock_gate_pkg::bus_req_t i_bus = '0;
  logic [31:0]              o_rdata;
  logic [2:0]               o_prog_clk_on;
  logic [31:0]              o_periph_clk;
  logic                     o_irq;
  int                       err_total = 0;
  int                       n_compared = 0;
  int                       seed = 78;
  int                       cyc = 0;
  logic [2:0]               sys;
  logic [31:0]              ps, mask, evt, en, exp_r, d;
  logic [7:0]               src, a;
  logic                     viol, w;
  logic                     pend = 1'b0;
  logic [31:0]              rw [256];
  logic [7:0]               tbl [32] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
    8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c, 8'h40,
    8'h44, 8'h48, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h74, 8'h78, 8'h80,
    8'h84, 8'h88, 8'h90, 8'he4, 8'he8, 8'hec, 8'hfc};
  always #2 i_mclk = ~i_mclk;
  clock_gating_register_interface #(
    .PERIPH_IMPL(IMPL)
  ) DUT (
    .i_mclk        (i_mclk),
    .i_rst         (i_rst),
    .i_bus         (i_bus),
    .o_rdata       (o_rdata),
    .o_prog_clk_on (o_prog_clk_on),
    .o_periph_clk  (o_periph_clk),
    .o_irq         (o_irq)
  );
  // *****
  // Reference model and bus tasks.
  // *****
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic is_rw(input logic [7:0] x);
    return x inside {8'h1c, 8'h20, 8'h28, 8'h30, 8'h40, 8'h44, 8'h48,
      8'h70, 8'h74, 8'he4};
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] x);
    case (x)
      8'h08: return {21'h0, sys, 8'h01};
      8'h18: return ps;
      8'h68: return clock_gate_pkg::RST_CONTROLLER_STATUS;
      8'h6c: return mask;
      8'h80: return evt;
      8'h88: return en;
      8'he8: return {16'h0000, src, 7'h00, viol};
      default: return is_rw(x) ? rw[x] : 32'h0000_0000;
    endcase
  endfunction
  task automatic apply(input logic [7:0] x, input logic [31:0] v);
    if (rw[8'he4][0] && x inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h1c, 8'h20,
        8'h28, 8'h40, 8'h44, 8'h48, 8'h70, 8'h74})
    begin
      viol = 1'b1;
      src = x;
      evt[0] = 1'b1;
    end
    else
    begin
      if (x == 8'h00)
        evt[10:8] = evt[10:8] | (v[10:8] & ~sys);
      case (x)
        8'h00: sys = sys | v[10:8];
        8'h04: sys = sys & ~v[10:8];
        8'h10: ps = ps | (v & IMPL);
        8'h14: ps = ps & ~(v & IMPL);
        8'h60: mask = mask | v;
        8'h64: mask = mask & ~v;
        8'h84: evt = evt & ~v;
        8'h88: en = v;
        default: if (is_rw(x)) rw[x] = v;
      endcase
    end
  endtask
  // A read issued at the previous edge is answered at this edge and compared 1 ns later, after the next request is driven.
  task automatic op(input logic [7:0] x, input logic [31:0] v,
                    input logic wq, input logic rq);
    @(posedge i_mclk);
    i_bus <= '{addr: x, wdata: v, wr: wq, rd: rq};
    #1;
    if (pend)
      chk("read data", exp_r, o_rdata);
    pend = rq;
    exp_r = exp_rd(x);
    if (rq && x == 8'he8)
      viol = 1'b0;
    if (wq)
      apply(x, v);
  endtask
  task automatic settle(input string nm);
    repeat (3) op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
    chk("prog outputs", {29'h0, sys}, {29'h0, o_prog_clk_on});
    chk("irq", {31'h0, |(evt & en)}, {31'h0, o_irq});
    chk("gated clocks", ps, o_periph_clk);
    $display("test %s done", nm);
  endtask
  task automatic do_reset();
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    {sys, ps, mask, evt, en, src, viol, pend} = '0;
    foreach (rw[j]) rw[j] = 32'h0000_0000;
    rw[8'h1c] = 32'h1020_0800;
    rw[8'h20] = 32'h0000_0001;
    rw[8'h28] = 32'h0000_3f00;
    rw[8'h30] = 32'h0000_0001;
    foreach (tbl[k]) op(tbl[k], 32'h0000_0000, 1'b0, 1'b1);
    op(8'h68, 32'h0000_0000, 1'b0, 1'b1);
    settle("reset values");
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
  end
  // *****
  // Scenarios.
  // *****
  initial
  begin
    do_reset();
    op(8'h00, 32'h0000_0700, 1'b1, 1'b0);
    op(8'h04, 32'h0000_0200, 1'b1, 1'b0);
    op(8'h08, 32'h0000_0000, 1'b0, 1'b1);
    op(8'h80, 32'h0000_0000, 1'b0, 1'b1);
    settle("prog masked");
    op(8'h88, 32'h0000_0701, 1'b1, 1'b0);
    settle("irq raised");
    op(8'h84, 32'h0000_0700, 1'b1, 1'b0);
    settle("irq cleared");
    op(8'h10, 32'hffff_ffff, 1'b1, 1'b0);
    op(8'h18, 32'h0000_0000, 1'b0, 1'b1);
    op(8'h14, 32'h0000_0010, 1'b1, 1'b0);
    op(8'h18, 32'h0000_0000, 1'b0, 1'b1);
    settle("peripheral clocks");
    op(8'he4, 32'h0000_0001, 1'b1, 1'b0);
    op(8'h10, 32'h0000_0010, 1'b1, 1'b0);
    op(8'he8, 32'h0000_0000, 1'b0, 1'b1);
    op(8'he8, 32'h0000_0000, 1'b0, 1'b1);
    op(8'h04, 32'h0000_0700, 1'b1, 1'b0);
    op(8'he4, 32'h0000_0000, 1'b1, 1'b0);
    settle("write guard");
    for (int k = 0; k < 400; k++)
    begin
      a = tbl[$unsigned($random(seed)) % 32];
      d = $random(seed);
      w = d[31] ^ d[0];
      if (a == 8'h88)
        d = d & 32'h0000_0701;
      op(a, d, w, !w);
      if (k % 100 == 99)
        settle("random block");
    end
    do_reset();
    conclude();
  end
endmodule
`default_nettype wire
